/* File: acr_cal_ctrl.sv */
// Summary of operation
// - Internal zero-scale shorts input, two cycles.
// - Ready goes high at start, low at end.
// - Mode returns to idle after calibration.
// - Zero-scale result stored in channel offset.
// - Internal full-scale applies full-scale stimulus.
// - Internal full-scale: two cycles unity, else four.
// - Full-scale result stored in channel full-scale.
// - Internal full-scale refused at gain 128.
// - System zero-scale completes in two cycles.
// - System full-scale completes in two cycles.
// - Rate code maps to rate and settling.
// - Idle holds filter, modulator in reset.
`timescale 1ns/1ns
`default_nettype none

module acr_cal_ctrl (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic        MODE_WR,
  input  wire logic [2:0]  OP_MODE_SEL,
  input  wire logic [2:0]  INPUT_CHANNEL_SEL,
  input  wire logic [2:0]  GAIN_SEL,
  input  wire logic [3:0]  UPDATE_RATE_SEL,
  input  wire logic        CONV_TICK,
  input  wire logic [23:0] MEAS_DATA,
  input  wire logic [2:0]  COEF_RD_CH,
  output logic [2:0]       OP_MODE,
  output logic             RDY_N,
  output logic             CAL_BUSY,
  output logic             CAL_REJECT,
  output logic [2:0]       CAL_CHANNEL,
  output logic [2:0]       CAL_GAIN,
  output logic             INT_SHORT,
  output logic             INT_FS_APPLY,
  output logic             MOD_RESET,
  output logic             MOD_CLK_EN,
  output logic [23:0]      OFFSET_COEF,
  output logic [23:0]      FULL_SCALE_COEF,
  output logic [15:0]      OUTPUT_UPDATE_RATE,
  output logic [8:0]       SETTLE_MS,
  output logic             RATE_RESERVED
);

  // ---------------------------------------------------------------------------
  // Rate decoding
  // ---------------------------------------------------------------------------
  acr_pkg::acr_rate_t rate_w;
  acr_pkg::acr_regs_t r_q;
  acr_pkg::acr_regs_t r_d;
  logic               is_cal;
  logic               is_fs_cal;
  logic               refuse;
  logic               last_tick;

  acr_rate_dec u_rate (
    .sel  (UPDATE_RATE_SEL),
    .rate (rate_w)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  assign is_cal    = OP_MODE_SEL[2];
  assign is_fs_cal = r_q.mode[0];
  assign refuse    = (OP_MODE_SEL == acr_pkg::MODE_INT_FS) && (GAIN_SEL == acr_pkg::GAIN_128);
  assign last_tick = CONV_TICK && (r_q.cnt + 3'h1 == r_q.need);

  always_comb begin
    r_d          = r_q;
    r_d.rate     = rate_w;
    r_d.ofs_out  = 24'h000000;
    r_d.fs_out   = 24'h000000;
    if (32'(COEF_RD_CH) < acr_pkg::NUM_CH) begin
      r_d.ofs_out = r_q.ofs[COEF_RD_CH[1:0]];
      r_d.fs_out  = r_q.fs[COEF_RD_CH[1:0]];
    end
    unique case (r_q.st)
      acr_pkg::ST_RUN: begin
        if (CONV_TICK && r_q.mode == acr_pkg::MODE_CONT) begin
          r_d.rdy_n = 1'b0;
        end
        if (MODE_WR) begin
          r_d.reject = refuse;
          if (refuse) begin
            // A refused request leaves the mode as it was so no bogus coefficient lands.
            r_d.reject = 1'b1;
          end else if (is_cal) begin
            r_d.st       = acr_pkg::ST_CAL;
            r_d.mode     = OP_MODE_SEL;
            r_d.rdy_n    = 1'b1;
            r_d.cnt      = 3'h0;
            r_d.ch       = INPUT_CHANNEL_SEL;
            r_d.gain     = GAIN_SEL;
            r_d.short_in = (OP_MODE_SEL == acr_pkg::MODE_INT_ZS);
            r_d.fs_apply = (OP_MODE_SEL == acr_pkg::MODE_INT_FS);
            r_d.mod_rst  = 1'b0;
            // A calibration straight out of power-down needs the modulator clock back.
            r_d.mod_clk_en = 1'b1;
            if (OP_MODE_SEL == acr_pkg::MODE_INT_FS && GAIN_SEL != acr_pkg::GAIN_UNITY) begin
              r_d.need = acr_pkg::CAL_CYC_LONG;
            end else begin
              r_d.need = acr_pkg::CAL_CYC_SHORT;
            end
          end else begin
            r_d.mode       = OP_MODE_SEL;
            r_d.rdy_n      = 1'b1;
            r_d.mod_rst    = (OP_MODE_SEL == acr_pkg::MODE_IDLE) ||
                             (OP_MODE_SEL == acr_pkg::MODE_PDOWN);
            r_d.mod_clk_en = (OP_MODE_SEL != acr_pkg::MODE_PDOWN);
          end
        end
      end
      acr_pkg::ST_CAL: begin
        // Mode writes are ignored here; a half-finished coefficient is never stored.
        if (CONV_TICK) begin
          r_d.cnt = r_q.cnt + 3'h1;
        end
        if (last_tick) begin
          if (32'(r_q.ch) < acr_pkg::NUM_CH) begin
            if (is_fs_cal) begin
              r_d.fs[r_q.ch[1:0]] = MEAS_DATA;
            end else begin
              r_d.ofs[r_q.ch[1:0]] = MEAS_DATA;
            end
          end
          r_d.st         = acr_pkg::ST_RUN;
          r_d.mode       = acr_pkg::MODE_IDLE;
          r_d.rdy_n      = 1'b0;
          r_d.short_in   = 1'b0;
          r_d.fs_apply   = 1'b0;
          r_d.mod_rst    = 1'b1;
          r_d.mod_clk_en = 1'b1;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r_q            <= '0;
      r_q.st         <= acr_pkg::ST_RUN;
      r_q.mode       <= acr_pkg::MODE_RESET;
      r_q.need       <= acr_pkg::CAL_CYC_SHORT;
      r_q.rdy_n      <= 1'b1;
      r_q.mod_clk_en <= 1'b1;
      r_q.ofs        <= {acr_pkg::NUM_CH{acr_pkg::OFS_RESET}};
      r_q.fs         <= {acr_pkg::NUM_CH{acr_pkg::FS_RESET}};
    end else begin
      r_q <= r_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign OP_MODE            = r_q.mode;
  assign RDY_N              = r_q.rdy_n;
  assign CAL_BUSY           = (r_q.st == acr_pkg::ST_CAL);
  assign CAL_REJECT         = r_q.reject;
  assign CAL_CHANNEL        = r_q.ch;
  assign CAL_GAIN           = r_q.gain;
  assign INT_SHORT          = r_q.short_in;
  assign INT_FS_APPLY       = r_q.fs_apply;
  assign MOD_RESET          = r_q.mod_rst;
  assign MOD_CLK_EN         = r_q.mod_clk_en;
  assign OFFSET_COEF        = r_q.ofs_out;
  assign FULL_SCALE_COEF    = r_q.fs_out;
  assign OUTPUT_UPDATE_RATE = r_q.rate.rate_chz;
  assign SETTLE_MS          = r_q.rate.settle_ms;
  assign RATE_RESERVED      = r_q.rate.reserved;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  logic [2:0] tick_seen_q;
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tick_seen_q <= 3'h0;
    end else if (!CAL_BUSY) begin
      tick_seen_q <= 3'h0;
    end else if (CONV_TICK) begin
      tick_seen_q <= tick_seen_q + 3'h1;
    end
  end

  a_short_int_zs: assert property (INT_SHORT |-> CAL_BUSY && OP_MODE == acr_pkg::MODE_INT_ZS)
    else $error("Input short outside internal zero-scale calibration.");
  a_rdy_during_cal: assert property (CAL_BUSY |-> RDY_N)
    else $error("Ready low while calibrating.");
  a_rdy_low_end: assert property ($fell(CAL_BUSY) |-> !RDY_N && OP_MODE == acr_pkg::MODE_IDLE)
    else $error("Calibration end without ready low and idle.");
  a_ofs_stored: assert property (CAL_BUSY && last_tick && !OP_MODE[0] && CAL_CHANNEL == 3'h0
    |=> r_q.ofs[0] == $past(MEAS_DATA))
    else $error("Offset coefficient not stored.");
  a_fs_apply: assert property (INT_FS_APPLY |-> OP_MODE == acr_pkg::MODE_INT_FS && CAL_BUSY)
    else $error("Full-scale stimulus outside its calibration.");
  a_cal_length: assert property ($fell(CAL_BUSY) |-> $past(tick_seen_q) + 3'h1 == $past(r_q.need))
    else $error("Calibration length wrong.");
  a_long_gain: assert property (CAL_BUSY && OP_MODE == acr_pkg::MODE_INT_FS |->
    (r_q.need == acr_pkg::CAL_CYC_LONG) == (CAL_GAIN != acr_pkg::GAIN_UNITY))
    else $error("Internal full-scale length does not follow gain.");
  a_fs_stored: assert property (CAL_BUSY && last_tick && OP_MODE[0] && CAL_CHANNEL == 3'h1
    |=> r_q.fs[1] == $past(MEAS_DATA))
    else $error("Full-scale coefficient not stored.");
  a_gain128_refused: assert property (!CAL_BUSY && MODE_WR && refuse |=> !CAL_BUSY && CAL_REJECT)
    else $error("Internal full-scale accepted at gain 128.");
  a_rate_track: assert property ($past(RESET_N) |->
    OUTPUT_UPDATE_RATE == acr_pkg::RATE_CHZ[$past(UPDATE_RATE_SEL)])
    else $error("Update rate does not follow the rate code.");
  a_idle_reset: assert property (OP_MODE == acr_pkg::MODE_IDLE |-> MOD_RESET && MOD_CLK_EN)
    else $error("Idle without filter reset or modulator clock.");
  a_latched_setup: assert property (CAL_BUSY && $past(CAL_BUSY) |-> $stable(CAL_CHANNEL) && $stable(CAL_GAIN))
    else $error("Calibration setup changed mid-calibration.");

endmodule : acr_cal_ctrl

`default_nettype wire

/* File: acr_pkg.sv */
`default_nettype none

package acr_pkg;

  // ---------------------------------------------------------------------------
  // Operating mode codes
  // ---------------------------------------------------------------------------
  localparam logic [2:0] MODE_CONT     = 3'h1;
  localparam logic [2:0] MODE_IDLE     = 3'h2;
  localparam logic [2:0] MODE_PDOWN    = 3'h3;
  localparam logic [2:0] MODE_INT_ZS   = 3'h4;
  localparam logic [2:0] MODE_INT_FS   = 3'h5;
  localparam logic [2:0] MODE_SYS_ZS   = 3'h6;
  localparam logic [2:0] MODE_SYS_FS   = 3'h7;
  localparam logic [2:0] MODE_RESET    = 3'h1;

  // ---------------------------------------------------------------------------
  // Gain codes and calibration lengths in conversion cycles
  // ---------------------------------------------------------------------------
  localparam logic [2:0] GAIN_UNITY    = 3'h0;
  localparam logic [2:0] GAIN_128      = 3'h7;
  localparam logic [2:0] CAL_CYC_SHORT = 3'h2;
  localparam logic [2:0] CAL_CYC_LONG  = 3'h4;

  // ---------------------------------------------------------------------------
  // Channels and coefficient width
  // ---------------------------------------------------------------------------
  localparam int         NUM_CH        = 3;
  localparam int         COEF_W        = 24;
  localparam logic [23:0] OFS_RESET    = 24'h800000;
  localparam logic [23:0] FS_RESET     = 24'h500000;

  // ---------------------------------------------------------------------------
  // Update rate table, rate in units of 0.01 Hz, settling time in ms
  // ---------------------------------------------------------------------------
  localparam logic [3:0] RATE_RESERVED = 4'h0;
  localparam logic [15:0] RATE_CHZ [16] = '{
    16'h0000, 16'hC350, 16'h61A8, 16'h30D4, 16'h186A, 16'h1388, 16'h0F50, 16'h0D02,
    16'h07A8, 16'h0686, 16'h0686, 16'h04E2, 16'h03E8, 16'h0341, 16'h0271, 16'h01A1};
  localparam logic [8:0] SETTLE_MS [16] = '{
    9'h000, 9'h004, 9'h008, 9'h010, 9'h020, 9'h028, 9'h030, 9'h03C,
    9'h065, 9'h078, 9'h078, 9'h0A0, 9'h0C8, 9'h0F0, 9'h140, 9'h1E0};

  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_CAL = 1'b1
  } acr_state_e_t;

  typedef struct packed {
    logic [15:0] rate_chz;
    logic [8:0]  settle_ms;
    logic        reserved;
  } acr_rate_t;

  typedef struct packed {
    acr_state_e_t                  st;
    logic [2:0]                    mode;
    logic [2:0]                    cnt;
    logic [2:0]                    need;
    logic [2:0]                    ch;
    logic [2:0]                    gain;
    logic                          rdy_n;
    logic                          reject;
    logic                          short_in;
    logic                          fs_apply;
    logic                          mod_rst;
    logic                          mod_clk_en;
    logic [NUM_CH-1:0][COEF_W-1:0] ofs;
    logic [NUM_CH-1:0][COEF_W-1:0] fs;
    logic [COEF_W-1:0]             ofs_out;
    logic [COEF_W-1:0]             fs_out;
    acr_rate_t                     rate;
  } acr_regs_t;

endpackage : acr_pkg

`default_nettype wire

/* File: acr_rate_dec.sv */
`timescale 1ns/1ns
`default_nettype none

module acr_rate_dec (
  input  wire logic [3:0]      sel,
  output var acr_pkg::acr_rate_t rate
);

  always_comb begin
    rate.rate_chz  = acr_pkg::RATE_CHZ[sel];
    rate.settle_ms = acr_pkg::SETTLE_MS[sel];
    rate.reserved  = (sel == acr_pkg::RATE_RESERVED);
  end

endmodule : acr_rate_dec

`default_nettype wire

/* File: acr_conv_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------------------
// Conversion source standing in for the filter's conversion tick and measured data
// ---------------------------------------------------------------------------
module acr_conv_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  output var  logic        tick,
  output var  logic [23:0] meas
);
  logic [1:0] cnt_q;

  // The measured data changes every cycle, so a stale sample never matches by luck.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
      tick  <= 1'b0;
      meas  <= 24'h000000;
    end else begin
      cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
      tick  <= (cnt_q == 2'h2);
      meas  <= 24'($urandom);
    end
  end
endmodule : acr_conv_model

`default_nettype wire

/* File: acr_cal_ctrl_test.sv */
`timescale 1ns/1ns
`default_nettype none

module acr_cal_ctrl_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr = 1'b0;
  logic [2:0]  msel = 3'h2, chs = 3'h0, gsel = 3'h0, rdch = 3'h0;
  logic [3:0]  rsel = 4'h1;
  logic        tick, rdy_n, busy, rej, shrt, fsap, mrst, mclk, rres;
  logic [23:0] meas, ofs_c, fs_c;
  logic [2:0]  op_mode, cal_ch, cal_gain;
  logic [15:0] rate;
  logic [8:0]  settle;
  int          bad_count = 0, num_checks = 0, md = 1;
  int          ofs_m[3] = '{3{32'h800000}};
  int          fs_m[3] = '{3{32'h500000}};
  int          rate_m[16] = '{0, 50000, 25000, 12500, 6250, 5000, 3920, 3330,
                              1960, 1670, 1670, 1250, 1000, 833, 625, 417};
  int          set_m[16] = '{0, 4, 8, 16, 32, 40, 48, 60, 101, 120, 120, 160, 200, 240, 320, 480};

  always #4 clk = ~clk;

  acr_cal_ctrl u_dut (
    .SYS_CLK(clk), .RESET_N(rst_n), .MODE_WR(wr), .OP_MODE_SEL(msel),
    .INPUT_CHANNEL_SEL(chs), .GAIN_SEL(gsel), .UPDATE_RATE_SEL(rsel), .CONV_TICK(tick),
    .MEAS_DATA(meas), .COEF_RD_CH(rdch), .OP_MODE(op_mode), .RDY_N(rdy_n), .CAL_BUSY(busy),
    .CAL_REJECT(rej), .CAL_CHANNEL(cal_ch), .CAL_GAIN(cal_gain), .INT_SHORT(shrt),
    .INT_FS_APPLY(fsap), .MOD_RESET(mrst), .MOD_CLK_EN(mclk), .OFFSET_COEF(ofs_c),
    .FULL_SCALE_COEF(fs_c), .OUTPUT_UPDATE_RATE(rate), .SETTLE_MS(settle),
    .RATE_RESERVED(rres)
  );

  acr_conv_model u_conv (.clk(clk), .rst_n(rst_n), .tick(tick), .meas(meas));

  // ---------------------------------------------------------------------------
  // Comparison and closing
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------------------
  // One calibration request, with the settings scrambled once it is taken
  // ---------------------------------------------------------------------------
  task automatic cal(input logic [2:0] m, input logic [2:0] ch, input logic [2:0] g);
    int n = 0;
    int last = 0;
    int want = 2;
    int r = ch % 3;
    @(posedge clk);
    wr   <= 1'b1;
    msel <= m;
    chs  <= ch;
    gsel <= g;
    @(posedge clk);
    wr   <= 1'b0;
    chs  <= 3'($urandom);
    gsel <= 3'($urandom);
    @(negedge clk);
    if (m == acr_pkg::MODE_INT_FS && g == acr_pkg::GAIN_128) begin
      chk({rej, busy, op_mode}, {1'b1, 1'b0, 3'(md)});
    end else begin
      if (m == acr_pkg::MODE_INT_FS && g != acr_pkg::GAIN_UNITY)
        want = 4;
      chk({rdy_n, shrt, fsap}, {1'b1, m == acr_pkg::MODE_INT_ZS, m == acr_pkg::MODE_INT_FS});
      for (int k = 0; k < 200 && busy === 1'b1; k++) begin
        chk({cal_ch, cal_gain}, {ch, g});
        if (tick === 1'b1) begin
          n++;
          last = meas;
        end
        @(negedge clk);
      end
      chk(n, want);
      chk({op_mode, rdy_n, busy, mrst, mclk, shrt, fsap}, {3'h2, 6'h0C});
      md = 2;
      if (ch < 3 && m[0])
        fs_m[ch] = last;
      else if (ch < 3)
        ofs_m[ch] = last;
    end
    @(posedge clk);
    rdch <= 3'(r);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({ofs_c, fs_c}, {24'(ofs_m[r]), 24'(fs_m[r])});
  endtask : cal

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(90477));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      rsel <= 4'(i);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({rate, settle, rres}, {16'(rate_m[i]), 9'(set_m[i]), i == 0});
    end
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      wr   <= 1'b1;
      msel <= 3'(3 - j);
      @(posedge clk);
      wr   <= 1'b0;
      @(negedge clk);
      chk({op_mode, rdy_n, mrst, mclk, rej}, {3'(3 - j), 1'b1, 1'b1, j == 1, 1'b0});
    end
    md = 2;
    cal(3'h4, 3'h0, 3'h1);
    cal(3'h5, 3'h1, 3'h0);
    cal(3'h5, 3'h2, 3'h3);
    cal(3'h5, 3'h2, 3'h7);
    cal(3'h6, 3'h2, 3'h7);
    cal(3'h7, 3'h1, 3'h7);
    repeat (10) cal(3'h4 + 3'($urandom % 4), 3'($urandom), 3'($urandom));
    give_verdict();
  end

  // A hang is cut well beyond the few hundred cycles the sequence needs.
  initial begin
    #160000;
    bad_count++;
    give_verdict();
  end
endmodule : acr_cal_ctrl_test

`default_nettype wire
